// ===== hdl/dmadc_top.sv
// Function
// [R1] Destination register shows next write address.
// [R2] Single address mode leaves destination unused.
// [R3] Software aligns address to transfer size.
// [R4] Software aligns 16-byte units to 16 bytes.
// [R5] Count value is transfers; zero means maximum.
// [R6] Count register shows transfers still remaining.
// [R7] Count top byte reads zero, write zero.
// [R8] One 16-byte unit decrements count once.
// [R9] Address and count have no reset value.
// [R10] Burst mode keeps bus until end.
// [R11] Level burst releases bus when request drops.
// [R12] External device drives request input.
// [R13] Drive acknowledge strobe to served device.
// [R14] Transfer-end outputs mark end of transfers.
// [R15] Count zero ends channel, flags final transfer.
`timescale 1ns/10ps

// ************************************************************
// Data FIFO between the source stream and the memory port.
// ************************************************************
module dmadc_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];  // Storage, no reset needed.
    logic [PW:0] wr_q;            // Write pointer with wrap bit.
    logic [PW:0] rd_q;            // Read pointer with wrap bit.
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Full when pointers differ only in the wrap bit.
    assign in_ready = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem_q[rd_q[PW-1:0]];

    // Storage is written only when a word is accepted.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[PW-1:0]] <= in_data;
        end
    end

    // Pointers move on each accepted push and pop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (PW+1)'(push);
            rd_q <= rd_q + (PW+1)'(pop);
        end
    end
endmodule

// ************************************************************
// Destination address, transfer count and burst handshake engine.
// ************************************************************
module dmadc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [dmadc_pkg::PAW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic src_valid,
    output logic src_ready,
    input wire logic [dmadc_pkg::DW-1:0] src_data,
    input wire logic [dmadc_pkg::NCH-1:0] ext_transfer_request,
    output logic [dmadc_pkg::NCH-1:0] transfer_ack_strobe,
    output logic [dmadc_pkg::NTEND-1:0] transfer_end_output,
    output logic bus_req,
    input wire logic bus_grant,
    output dmadc_pkg::dmadc_wr_t mem_wr,
    input wire logic mem_ready
);
    import dmadc_pkg::*;

    // ************************************************************
    // State and storage.
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_BEAT} dmadc_state_t;

    dmadc_state_t state_q;                // Engine state.
    dmadc_state_t state_d;                // Next engine state.
    logic [1:0] cur_q;                    // Channel being served.
    logic [1:0] pick_d;                   // Highest-priority pending channel.
    logic [1:0] beat_q;                   // Beat within a 16-byte unit.
    logic [AW-1:0] dest_q [NCH];          // Destination address registers.
    logic [CW-1:0] cnt_q [NCH];           // Remaining transfer counts.
    dmadc_ctrl_t ctrl_q [NCH];            // Channel control registers.
    logic [NCH-1:0] done_q;               // Sticky end-of-transfer flags.
    logic [NCH-1:0] pend_q;               // Latched request edges.
    logic [NCH-1:0] req_s1_q;             // Request synchroniser, first stage.
    logic [NCH-1:0] req_s2_q;             // Request synchroniser, second stage.
    logic [NCH-1:0] req_s3_q;             // Request synchroniser, third stage.
    logic [NCH-1:0] req_lvl_q;            // Filtered request level.
    logic [NCH-1:0] req_old_q;            // Previous filtered level for edges.
    logic [NCH-1:0] pending;              // Channel wants service.
    logic fifo_valid;                     // FIFO holds a word for the memory port.
    logic [DW-1:0] fifo_data;             // Word at the head of the FIFO.

    // ************************************************************
    // APB decode; the slave answers with no wait state.
    // ************************************************************
    wire apb_acc = psel & penable;
    wire mapped = (paddr < MAP_TOP) && (paddr[1:0] == 2'b00);
    wire [1:0] sel_ch = paddr[CH_SEL_LSB+1:CH_SEL_LSB];
    wire [3:0] reg_ofs = paddr[3:0];
    wire apb_wr = apb_acc & pwrite & mapped;
    assign pready = 1'b1;
    assign pslverr = apb_acc & !mapped;

    // ************************************************************
    // Current-channel views used by the engine.
    // ************************************************************
    dmadc_ctrl_t cur_ctrl;
    logic [AW-1:0] cur_dest;
    logic [CW-1:0] cur_cnt;
    logic [AW-1:0] addr_inc;
    assign cur_ctrl = ctrl_q[cur_q];
    assign cur_dest = dest_q[cur_q];
    assign cur_cnt = cnt_q[cur_q];
    wire cur_last = (cur_cnt == CNT_LAST);  // [R15]
    wire in_beat = (state_q == ST_BEAT);
    wire beat = in_beat & fifo_valid & mem_ready;
    // A 16-byte unit only completes on its fourth beat.
    wire unit_done = beat & ((cur_ctrl.size != SZ_16B) | (beat_q == BEATS_16B_LAST));  // [R8]
    wire end_hit = unit_done & cur_last;  // [R15]

    // Address step per beat; single address mode never moves it.
    assign addr_inc = cur_ctrl.single ? '0 :
                      (cur_ctrl.size == SZ_BYTE) ? INC_BYTE :
                      (cur_ctrl.size == SZ_HALF) ? INC_HALF : INC_WORD;  // [R2]

    // ************************************************************
    // Per-channel registers and request synchronisers.
    // ************************************************************
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            wire hit = apb_wr & (sel_ch == 2'(c));
            wire wr_dest = hit & (reg_ofs == OFS_DEST);
            wire wr_cnt = hit & (reg_ofs == OFS_COUNT);
            wire wr_ctrl = hit & (reg_ofs == OFS_CTRL);
            wire wr_stat = hit & (reg_ofs == OFS_STAT);
            wire mine = (cur_q == 2'(c));
            wire rise = req_lvl_q[c] & !req_old_q[c];

            assign pending[c] = ctrl_q[c].en & (ctrl_q[c].level ? req_lvl_q[c] : pend_q[c]);

            // Address and count carry no reset; software loads them first.
            always_ff @(posedge pclk) begin  // [R9]
                if (wr_dest) begin
                    dest_q[c] <= pwdata;
                end else if (beat & mine) begin
                    dest_q[c] <= dest_q[c] + addr_inc;  // [R1]
                end
            end

            // The top byte of a count write is dropped, so it reads zero.
            always_ff @(posedge pclk) begin
                if (wr_cnt) begin
                    cnt_q[c] <= pwdata[CW-1:0];  // [R7]
                end else if (unit_done & mine) begin
                    cnt_q[c] <= cnt_q[c] - CNT_LAST;  // [R5] [R6]
                end
            end

            // Control; a software write wins over the end-of-transfer clear.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_q[c] <= CTRL_RESET;
                end else if (wr_ctrl) begin
                    ctrl_q[c] <= pwdata[CTRL_W-1:0];
                end else if (end_hit & mine) begin
                    ctrl_q[c].en <= 1'b0;  // [R15]
                end
            end

            // Done is cleared by writing one; a new end in that cycle wins.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    done_q[c] <= 1'b0;
                end else begin
                    done_q[c] <= (end_hit & mine) | (done_q[c] & !(wr_stat & pwdata[STAT_DONE_BIT]));
                end
            end

            // Three stages; a change is taken once stages two and three agree.
            always_ff @(posedge pclk or negedge presetn) begin  // [R12]
                if (!presetn) begin
                    req_s1_q[c] <= 1'b0;
                    req_s2_q[c] <= 1'b0;
                    req_s3_q[c] <= 1'b0;
                    req_lvl_q[c] <= 1'b0;
                    req_old_q[c] <= 1'b0;
                end else begin
                    req_s1_q[c] <= ext_transfer_request[c];
                    req_s2_q[c] <= req_s1_q[c];
                    req_s3_q[c] <= req_s2_q[c];
                    req_lvl_q[c] <= (req_s2_q[c] == req_s3_q[c]) ? req_s3_q[c] : req_lvl_q[c];
                    req_old_q[c] <= req_lvl_q[c];
                end
            end

            // An edge request is held until a unit for it completes; a new edge wins.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pend_q[c] <= 1'b0;
                end else begin
                    pend_q[c] <= rise | (pend_q[c] & !(unit_done & mine));
                end
            end

            // The strobe follows the beat presented for this channel.
            assign transfer_ack_strobe[c] = in_beat & mine & fifo_valid;  // [R13]
        end
    endgenerate

    // Only the first channels own an end pin; it marks the final unit.
    generate
        for (c = 0; c < NTEND; c++) begin : g_transfer_end_output
            assign transfer_end_output[c] = transfer_ack_strobe[c] & cur_last;  // [R14]
        end
    endgenerate

    // ************************************************************
    // Register read-back.
    // ************************************************************
    logic [31:0] rd_dest;
    logic [31:0] rd_cnt;
    logic [31:0] rd_ctrl;
    logic [31:0] rd_stat;
    wire rd_busy = (state_q != ST_IDLE) & (cur_q == sel_ch);
    assign rd_dest = dest_q[sel_ch];
    assign rd_cnt = {8'h00, cnt_q[sel_ch]};  // [R7]
    assign rd_ctrl = {{(32-CTRL_W){1'b0}}, ctrl_q[sel_ch]};
    assign rd_stat = {30'h0, done_q[sel_ch], rd_busy};
    assign prdata = !mapped ? 32'h0000_0000 :
                    (reg_ofs == OFS_DEST) ? rd_dest :
                    (reg_ofs == OFS_COUNT) ? rd_cnt :
                    (reg_ofs == OFS_CTRL) ? rd_ctrl : rd_stat;

    // ************************************************************
    // Channel selection: channel 0 has the highest priority.
    // ************************************************************
    always_comb begin
        pick_d = 2'd0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pending[i]) begin
                pick_d = 2'(i);
            end
        end
    end

    // ************************************************************
    // Engine sequencing and bus holding.
    // ************************************************************
    // Next state; cycle-steal releases the bus after every unit.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (|pending) begin
                    state_d = ST_ARB;
                end
            end
            ST_ARB: begin
                if (bus_grant) begin
                    state_d = ST_BEAT;
                end
            end
            ST_BEAT: begin
                if (!cur_ctrl.en) begin
                    state_d = ST_IDLE;
                end else if (end_hit) begin
                    state_d = ST_IDLE;  // [R15]
                end else if (unit_done & !cur_ctrl.burst) begin
                    state_d = ST_IDLE;
                end else if (unit_done & cur_ctrl.level & !req_lvl_q[cur_q]) begin
                    state_d = ST_IDLE;  // [R11]
                end else begin
                    state_d = ST_BEAT;  // [R10]
                end
            end
        endcase
    end

    // State, served channel and beat counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cur_q <= 2'd0;
            beat_q <= 2'd0;
        end else begin
            state_q <= state_d;
            cur_q <= (state_q == ST_IDLE) ? pick_d : cur_q;
            beat_q <= unit_done ? 2'd0 : (beat ? beat_q + 2'd1 : beat_q);
        end
    end

    // The bus is requested and held from selection until release.
    assign bus_req = (state_q != ST_IDLE);  // [R10]

    // ************************************************************
    // Data path and memory write port.
    // ************************************************************
    dmadc_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(src_valid),
        .in_ready(src_ready),
        .in_data(src_data),
        .out_valid(fifo_valid),
        .out_ready(in_beat & mem_ready),
        .out_data(fifo_data)
    );

    // In single address mode the address field is held at zero.
    assign mem_wr.valid = in_beat & fifo_valid;
    assign mem_wr.single = cur_ctrl.single;
    assign mem_wr.addr = (mem_wr.valid & !cur_ctrl.single) ? cur_dest : '0;  // [R2]
    assign mem_wr.data = fifo_data;

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire any_cnt_wr = apb_wr & (reg_ofs == OFS_COUNT);
    wire any_dest_wr = apb_wr & (reg_ofs == OFS_DEST);
    wire any_ctrl_wr = apb_wr & (reg_ofs == OFS_CTRL);
    sequence s_last_unit;
        unit_done && cur_last && !any_ctrl_wr;
    endsequence

    a_count_step: assert property (unit_done && !any_cnt_wr |=> // [R6]
        cnt_q[$past(cur_q)] == $past(cur_cnt) - CNT_LAST)
        else $error("count did not drop by one per unit");
    a_addr_next: assert property (beat && !cur_ctrl.single && !any_dest_wr |=> // [R1]
        dest_q[$past(cur_q)] == $past(cur_dest) + $past(addr_inc))
        else $error("destination did not advance by the unit step");
    a_single_hold: assert property (beat && cur_ctrl.single && !any_dest_wr |=> // [R2]
        $stable(dest_q[$past(cur_q)]) && mem_wr.addr == '0)
        else $error("destination moved in single address mode");
    a_count_top: assert property (psel && !pwrite && mapped && reg_ofs == OFS_COUNT |-> // [R7]
        prdata[31:24] == 8'h00)
        else $error("count top byte not zero");
    a_unit_16b: assert property (beat && cur_ctrl.size == SZ_16B && beat_q != BEATS_16B_LAST // [R8]
        && !any_cnt_wr |=> $stable(cnt_q[$past(cur_q)]))
        else $error("count moved inside a 16-byte unit");
    a_burst_hold: assert property (in_beat && cur_ctrl.en && cur_ctrl.burst // [R10]
        && !cur_ctrl.level && !end_hit |=> bus_req && in_beat)
        else $error("burst released the bus early");
    a_level_drop: assert property (unit_done && cur_ctrl.en && cur_ctrl.burst // [R11]
        && cur_ctrl.level && !cur_last && !req_lvl_q[cur_q] |=> !bus_req)
        else $error("level burst kept the bus after request dropped");
    a_ack_bus: assert property ($onehot0(transfer_ack_strobe) && // [R13]
        ((|transfer_ack_strobe) == mem_wr.valid))
        else $error("acknowledge strobe not tied to the write beat");
    a_transfer_end_output_last: assert property (transfer_end_output[0] |-> // [R14]
        transfer_ack_strobe[0] && cnt_q[0] == CNT_LAST)
        else $error("end pin outside final unit");
    a_end_stop: assert property (s_last_unit |=> // [R15]
        !ctrl_q[$past(cur_q)].en && done_q[$past(cur_q)] && !bus_req)
        else $error("channel not stopped at count zero");

endmodule

// ===== hdl/dmadc_pkg.sv
package dmadc_pkg;

    // ************************************************************
    // Sizes of the channel engine.
    // ************************************************************
    localparam int NCH = 4;          // Channels with request and acknowledge pins.
    localparam int NTEND = 2;        // Channels that own a transfer-end pin.
    localparam int AW = 32;          // Destination address width.
    localparam int CW = 24;          // Implemented transfer count width.
    localparam int DW = 32;          // Data path width.
    localparam int FIFO_DEPTH = 32;  // Words held between source and memory port.
    localparam int PAW = 8;          // APB address width.

    // ************************************************************
    // Register map: one 16-byte window per channel.
    // ************************************************************
    localparam logic [3:0] OFS_DEST = 4'h0;
    localparam logic [3:0] OFS_COUNT = 4'h4;
    localparam logic [3:0] OFS_CTRL = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hc;
    localparam logic [PAW-1:0] MAP_TOP = 8'h40;
    localparam int CH_SEL_LSB = 4;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int CTRL_W = 6;

    // ************************************************************
    // Reset values and counting constants.
    // ************************************************************
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    localparam logic [CW-1:0] CNT_LAST = 24'h000001;
    localparam logic [1:0] BEATS_16B_LAST = 2'h3;
    localparam logic [AW-1:0] INC_BYTE = 32'h0000_0001;
    localparam logic [AW-1:0] INC_HALF = 32'h0000_0002;
    localparam logic [AW-1:0] INC_WORD = 32'h0000_0004;

    // Transfer unit sizes; a 16-byte unit moves as four word beats.
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_LONG, SZ_16B} dmadc_size_t;

    // Channel control register; en sits in bit 0, size in bits 5:4.
    typedef struct packed {
        dmadc_size_t size;
        logic single;
        logic level;
        logic burst;
        logic en;
    } dmadc_ctrl_t;

    // Write beat toward the memory side.
    typedef struct packed {
        logic valid;
        logic single;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } dmadc_wr_t;

endpackage

// ===== dv/dmadc_periph.sv
`timescale 1ns/10ps

// ************************************************************
// Far side: requesting peripheral, bus arbiter and slow memory.
// ************************************************************
module dmadc_periph (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [dmadc_pkg::NCH-1:0] want,
    input wire logic [dmadc_pkg::NCH-1:0] transfer_ack_strobe,
    input wire logic bus_req,
    output logic [dmadc_pkg::NCH-1:0] ext_transfer_request,
    output logic bus_grant,
    output logic mem_ready
);
    import dmadc_pkg::*;
    logic [1:0] stall_q; // Free-running phase; memory refuses one beat in four.

    // A request is raised on demand and held until the strobe answers it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_transfer_request <= '0;
            bus_grant <= 1'b0;
            stall_q <= 2'h0;
        end else begin
            ext_transfer_request <= (ext_transfer_request | want) & ~transfer_ack_strobe;
            bus_grant <= bus_req; // Grant trails the bus request by one cycle.
            stall_q <= stall_q + 2'h1;
        end
    end

    // Stalls are late answers only, so the memory never loses a beat.
    assign mem_ready = (stall_q != 2'h3);
endmodule

// ===== dv/dmadc_top_tb.sv
`timescale 1ns/10ps

// ************************************************************
// Bench: APB programming, stream feed and beat checking.
// ************************************************************
module dmadc_top_tb;
    import dmadc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [PAW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, src_valid = 1'b0, src_ready, bus_req, bus_grant, mem_ready;
    logic [DW-1:0] src_data = '0;
    logic [NCH-1:0] want = '0, ext_transfer_request, transfer_ack_strobe;
    logic [NTEND-1:0] transfer_end_output;
    dmadc_wr_t mem_wr;
    logic [69:0] beats[$]; // Accepted beats: strobe, end flag, address, data.
    int miscompares = 0, n_tests = 0, next_data = 0;

    always #2 pclk = ~pclk; // 250 MHz.

    dmadc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_valid(src_valid), .src_ready(src_ready),
        .src_data(src_data), .ext_transfer_request(ext_transfer_request),
        .transfer_ack_strobe(transfer_ack_strobe), .transfer_end_output(transfer_end_output),
        .bus_req(bus_req), .bus_grant(bus_grant), .mem_wr(mem_wr), .mem_ready(mem_ready));

    dmadc_periph far (.pclk(pclk), .presetn(presetn), .want(want),
        .transfer_ack_strobe(transfer_ack_strobe), .bus_req(bus_req),
        .ext_transfer_request(ext_transfer_request), .bus_grant(bus_grant),
        .mem_ready(mem_ready));

    // Beats are logged mid-cycle, where the strobes have settled.
    always @(negedge pclk) begin
        if (mem_wr.valid === 1'b1 && mem_ready === 1'b1) begin
            beats.push_back({transfer_ack_strobe, transfer_end_output, mem_wr.addr, mem_wr.data});
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        logic rdy;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Data and error are taken at the very edge at which pready is seen high.
        do begin
            @(posedge pclk);
            r = prdata;
            e = pslverr;
            rdy = pready;
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask

    // Programs one channel, fires one request edge and checks every beat.
    task automatic run_ch(input int ch, input logic [7:0] ctrl, input logic [31:0] dest,
                          input int units, input int bpu);
        logic [7:0] b;
        logic [69:0] bt;
        logic single;
        b = 8'(ch * 16);
        single = ctrl[3];
        wr(b, dest);
        wr(b + 8'h04, {8'h00, 24'(units)});
        rd(b + 8'h04, {8'h00, 24'(units)}, 1'b0);
        wr(b + 8'h08, {24'h0, ctrl});
        want[ch] <= 1'b1;
        @(posedge pclk);
        want[ch] <= 1'b0;
        while (beats.size() < units * bpu) @(posedge pclk);
        for (int i = 0; i < units * bpu; i++) begin
            bt = beats.pop_front();
            chk(bt[63:32], single ? 32'h0 : dest + 32'(4 * i));
            chk(bt[31:0], 32'(next_data++));
            chk({28'h0, bt[69:66]}, 32'h1 << ch);
            chk({30'h0, bt[65:64]}, (ch < 2 && i >= (units - 1) * bpu) ? 32'h1 << ch : 32'h0);
        end
        rd(b + 8'h04, 32'h0, 1'b0);
        rd(b, single ? dest : dest + 32'(4 * units * bpu), 1'b0);
        rd(b + 8'h0c, 32'h2, 1'b0);
    endtask

    task automatic report_and_stop;
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        #(20000 * 4);
        miscompares++;
        report_and_stop;
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h40, 32'h0, 1'b1);
        rd(8'h02, 32'h0, 1'b1);
        // Fill the FIFO until it refuses, with every channel still idle.
        src_valid <= 1'b1;
        for (int n = 0; n < 32; ) begin
            @(negedge pclk);
            if (src_ready === 1'b1) n++;
            @(posedge pclk);
            src_data <= 32'(n);
        end
        @(negedge pclk);
        chk({31'h0, src_ready}, 32'h0);
        @(posedge pclk);
        src_valid <= 1'b0;
        // Every destination is word aligned, and the 16-byte unit sits on a 16-byte boundary.
        run_ch(0, 8'h23, 32'h0000_0100, 2, 1);
        run_ch(1, 8'h33, 32'h0000_0200, 1, 4);
        run_ch(2, 8'h2b, 32'h0000_0300, 1, 1);
        run_ch(3, 8'h23, 32'h0000_0400, 25, 1);
        @(negedge pclk);
        chk({31'h0, src_ready}, 32'h1);
        report_and_stop;
    end
endmodule
